// ### core/mbi_bus_if.sv
`default_nettype none
module mbi_bus_if
  import mbi_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mbi_pkg::mbi_mode_t bus_mode,
  input wire mbi_pkg::mbi_strobe_t strobe_map,
  input wire logic [1:0] ext_addr_port,
  input wire logic [1:0] addr_out_high_g,
  input wire logic latch_strobe_used,
  input wire logic [7:0] addr_data_port_in,
  output logic [7:0] addr_data_port_out,
  output logic addr_data_port_oe,
  input wire logic [7:0] port_f_in,
  input wire logic [3:0] port_a_in,
  input wire logic [3:0] port_b_in,
  input wire logic [3:0] port_c_in,
  input wire logic port_d_bit_zero,
  input wire logic control_input_first,
  input wire logic control_input_second,
  input wire logic control_input_third,
  input wire logic resource_hit,
  input wire logic [7:0] read_data,
  output logic [7:0] port_f_data_out,
  output logic port_f_data_oe,
  output logic [19:0] host_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_fetch,
  output logic logic_input_third,
  output logic ext_rd_strobe,
  output logic ext_wr_strobe,
  output logic [7:0] addr_out_e,
  output logic [7:0] addr_out_f,
  output logic [7:0] addr_out_g,
  input wire logic [7:0] sel_term,
  input wire logic [7:0] sel_active_low,
  input wire logic [7:0] sel_to_port_f,
  input wire logic [7:0] sel_oe_term,
  input wire logic [7:0] dir_port_c,
  input wire logic [7:0] dir_port_f,
  output logic [7:0] port_c_sel_out,
  output logic [7:0] port_c_sel_oe,
  output logic [7:0] port_f_sel_out,
  output logic [7:0] port_f_sel_oe
);
  // ================================================================
  // input synchronisers
  localparam int SW = 8 + 8 + 12 + 4;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  // strobes cross inverted: a flushed synchroniser must read idle, not active
  assign raw = {addr_data_port_in, port_f_in, port_a_in, port_b_in, port_c_in,
    port_d_bit_zero, !control_input_first, !control_input_second, !control_input_third};
  mbi_sync #(.W(SW)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(raw),
    .q(syn)
  );
  logic [7:0] ad_s, pf_s;
  logic [3:0] pa_s, pb_s, pc_s;
  logic ale_s, c0_a, c1_a, c2_a;
  logic c0_s, c1_s, c2_s;
  assign {ad_s, pf_s, pa_s, pb_s, pc_s, ale_s, c0_a, c1_a, c2_a} = syn;
  assign c0_s = !c0_a;
  assign c1_s = !c1_a;
  assign c2_s = !c2_a;

  // ================================================================
  // strobe decode
  logic rd_n, wr_n, program_fetch_strobe_n, e_clk, rw;
  always_comb begin
    rw = c0_s;
    e_clk = c1_s;
    wr_n = c0_s;
    rd_n = 1'b1;
    program_fetch_strobe_n = 1'b1;
    case (strobe_map)
      MBI_STB_RD_PROGRAM_FETCH_STROBE: begin
        rd_n = c1_s;
        program_fetch_strobe_n = c2_s;
      end
      MBI_STB_PROGRAM_FETCH_STROBE_ONLY: program_fetch_strobe_n = c1_s;
      MBI_STB_RD_ONLY: rd_n = c1_s;
      default: rd_n = c1_s;
    endcase
  end
  logic en_rw;
  assign en_rw = (bus_mode == MBI_MUX_EN_RW);
  always_comb begin
    if (en_rw) begin
      ext_rd_strobe = e_clk && rw;
      ext_wr_strobe = e_clk && !rw;
      mem_rd = e_clk && rw;
      mem_wr = e_clk && !rw;
      mem_fetch = 1'b0;
    end else begin
      ext_rd_strobe = 1'b0;
      ext_wr_strobe = 1'b0;
      mem_rd = !rd_n;
      mem_wr = !wr_n;
      mem_fetch = !program_fetch_strobe_n;
    end
  end
  // third control free when no fetch strobe is wired there
  assign logic_input_third = (strobe_map != MBI_STB_RD_PROGRAM_FETCH_STROBE) ? c2_s : 1'b0;

  // ================================================================
  // address latch
  logic ale_q, next_ale_q;
  logic [15:0] upper, next_upper;
  logic [3:0] ext_q, next_ext_q;
  logic strobe_fall;
  assign next_ale_q = ale_s;
  assign strobe_fall = ale_q && !ale_s;
  logic [3:0] ext_src;
  always_comb begin
    case (ext_addr_port)
      MBI_EXT_PA: ext_src = pa_s;
      MBI_EXT_PB: ext_src = pb_s;
      MBI_EXT_PC: ext_src = pc_s;
      MBI_EXT_PF: ext_src = (bus_mode == MBI_NONMUX) ? 4'h0 : pf_s[3:0];
      default: ext_src = pa_s;
    endcase
  end
  logic latch_en;
  // non-mux host without strobe: address is live, nothing to latch
  assign latch_en = strobe_fall && latch_strobe_used;
  always_comb begin
    next_upper = upper;
    next_ext_q = ext_q;
    if (latch_en) begin
      next_ext_q = ext_src;
      case (bus_mode)
        MBI_MUX_PAGE: next_upper = {ad_s, upper[7:0]};
        MBI_MUX_BURST: next_upper = {upper[15:12], ad_s, upper[3:0]};
        default: next_upper = {upper[15:8], ad_s};
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ale_q <= 1'b0;
      upper <= 16'h0000;
      ext_q <= 4'h0;
    end else begin
      ale_q <= next_ale_q;
      upper <= next_upper;
      ext_q <= next_ext_q;
    end
  end
  // ================================================================
  // address assembly
  logic [19:0] next_host_addr;
  always_comb begin
    case (bus_mode)
      // page hit: only low byte moves, upper byte held
      MBI_MUX_PAGE: next_host_addr = {ext_q, upper[15:8], pf_s};
      // burst: A3-0 dedicated lines on port F low nibble
      MBI_MUX_BURST: next_host_addr = {ext_q, 4'h0, upper[11:4], pf_s[3:0]};
      MBI_NONMUX: begin
        if (latch_strobe_used) next_host_addr = {ext_q, 8'h00, ad_s};
        else next_host_addr = {ext_src, 8'h00, ad_s};
      end
      default: next_host_addr = {ext_q, pf_s, upper[7:0]};
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) host_addr <= MBI_ADDR_RST;
    else host_addr <= next_host_addr;
  end
  // latched address out
  always_comb begin
    addr_out_e = upper[7:0];
    addr_out_f = upper[7:0];
    addr_out_g = addr_out_high_g[0] ? upper[15:8] : upper[7:0];
  end
  // ================================================================
  // data drive
  logic reading;
  assign reading = resource_hit && (mem_rd || mem_fetch);
  logic [7:0] dq, next_dq;
  assign next_dq = read_data;
  always_ff @(posedge mclk) begin
    if (sys_rst) dq <= MBI_BYTE_RST;
    else dq <= next_dq;
  end
  logic nonmux;
  assign nonmux = (bus_mode == MBI_NONMUX);
  assign addr_data_port_out = nonmux ? 8'h00 : dq;
  assign addr_data_port_oe = !nonmux && reading;
  assign port_f_data_out = nonmux ? dq : 8'h00;
  assign port_f_data_oe = nonmux && reading;
  // ================================================================
  mbi_sel #(.N(MBI_NUM_SEL)) u_sel (
    .sel_term(sel_term),
    .sel_active_low(sel_active_low),
    .sel_to_port_f(sel_to_port_f),
    .sel_oe_term(sel_oe_term),
    .dir_port_c(dir_port_c),
    .dir_port_f(dir_port_f),
    .port_c_sel_out(port_c_sel_out),
    .port_c_sel_oe(port_c_sel_oe),
    .port_f_sel_out(port_f_sel_out),
    .port_f_sel_oe(port_f_sel_oe)
  );
  // ================================================================
  AST_NONMUX_AD_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    nonmux |-> !addr_data_port_oe) else $error("ad port driven in nonmux");
  AST_AD_NEEDS_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    addr_data_port_oe |-> resource_hit && (mem_rd || mem_fetch))
    else $error("ad driven without read");
  AST_F_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    (nonmux && !resource_hit) |-> !port_f_data_oe) else $error("port f driven idle");
  AST_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    (latch_en && bus_mode == MBI_MUX_LOW) |=> upper[7:0] == $past(ad_s))
    else $error("low byte not latched");
  AST_PAGE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (!latch_en && bus_mode == MBI_MUX_PAGE) |=> $stable(upper))
    else $error("page upper moved");
  AST_STROBE_MAP: assert property (@(posedge mclk) disable iff (sys_rst)
    (strobe_map == MBI_STB_PROGRAM_FETCH_STROBE_ONLY && !en_rw) |-> !mem_rd && mem_fetch == !c1_s)
    else $error("single read mapping wrong");
  AST_EXT_STROBES: assert property (@(posedge mclk) disable iff (sys_rst)
    !(ext_rd_strobe && ext_wr_strobe)) else $error("both ext strobes");
  AST_SEL_OE: assert property (@(posedge mclk) disable iff (sys_rst)
    (port_c_sel_oe & port_f_sel_oe) == 8'h00) else $error("select on two ports");
  COV_PAGE: cover property (@(posedge mclk) latch_en && bus_mode == MBI_MUX_PAGE);
  COV_BURST: cover property (@(posedge mclk) latch_en && bus_mode == MBI_MUX_BURST);
  COV_NONMUX_RD: cover property (@(posedge mclk) port_f_data_oe);
  COV_EN_RW_RD: cover property (@(posedge mclk) ext_rd_strobe);
  COV_FETCH_ONLY: cover property (@(posedge mclk) strobe_map == MBI_STB_PROGRAM_FETCH_STROBE_ONLY && mem_fetch);
  AST_PAGE_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    (latch_en && bus_mode == MBI_MUX_PAGE) |=> upper[15:8] == $past(ad_s))
    else $error("page high byte not latched");
  AST_PAGE_ADDR: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus_mode == MBI_MUX_PAGE) |=> host_addr[15:8] == $past(upper[15:8]))
    else $error("page address lost upper byte");
  AST_BURST_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    (latch_en && bus_mode == MBI_MUX_BURST) |=> upper[11:4] == $past(ad_s))
    else $error("burst middle bits not latched");
  AST_BURST_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (!latch_en && bus_mode == MBI_MUX_BURST) |=> $stable(upper[11:4]))
    else $error("burst upper moved");
  AST_NO_STROBE: assert property (@(posedge mclk) disable iff (sys_rst)
    !latch_strobe_used |=> $stable(upper) && $stable(ext_q))
    else $error("latched without strobe");
  AST_NONMUX_NO_F_EXT: assert property (@(posedge mclk) disable iff (sys_rst)
    (nonmux && ext_addr_port == MBI_EXT_PF && !latch_strobe_used)
    |=> host_addr[19:16] == 4'h0) else $error("port f extra address in nonmux");
  AST_F_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    (nonmux && reading) |-> port_f_data_oe) else $error("nonmux read not driven");
  AST_RD_PROGRAM_FETCH_STROBE: assert property (@(posedge mclk) disable iff (sys_rst)
    (strobe_map == MBI_STB_RD_PROGRAM_FETCH_STROBE && !en_rw) |-> mem_fetch == !c2_s)
    else $error("fetch not on third control");
  AST_THIRD_BUSY: assert property (@(posedge mclk) disable iff (sys_rst)
    (strobe_map == MBI_STB_RD_PROGRAM_FETCH_STROBE) |-> !logic_input_third)
    else $error("third control leaked to logic");
endmodule : mbi_bus_if
`default_nettype wire

// ### core/mbi_pkg.sv
// Functional notes
// - eight external selects, one term, polarity
// - each select routes to port C or F
// - select pin enable: oe term or direction
// - multiplexed bus: latch address on strobe
// - latched address out on E, F, G
// - drive addr/data only on selected read
// - extra address bits: A,B,C,F or A,B,C
// - non-mux: address on port, data on F
// - non-mux: port F undriven when idle
// - unused third control becomes logic input
// - fetch, read, write strobes reach memories
// - latch strobe taken on port D bit 0
// - single read: fetch on second control
// - page host: address 16 on port A0
// - read on second, fetch on third control
// - page mode: data shares high address byte
// - page hit keeps latched upper address
// - burst host: A11-4 muxed, A3-0 dedicated
// - burst fetch holds upper, moves low four
// - enable plus direction gives read, write strobes
`default_nettype none
package mbi_pkg;
  // ================================================================
  // host bus styles
  typedef enum logic [2:0] {
    MBI_MUX_LOW   = 3'b000,
    MBI_MUX_PAGE  = 3'b001,
    MBI_MUX_BURST = 3'b010,
    MBI_NONMUX    = 3'b011,
    MBI_MUX_EN_RW = 3'b100
  } mbi_mode_t;
  // strobe wiring of the control inputs
  typedef enum logic [1:0] {
    MBI_STB_RD_PROGRAM_FETCH_STROBE = 2'b00,
    MBI_STB_PROGRAM_FETCH_STROBE_ONLY = 2'b01,
    MBI_STB_RD_ONLY = 2'b10
  } mbi_strobe_t;
  // ================================================================
  localparam int MBI_NUM_SEL = 8;
  localparam int MBI_PORT_W = 8;
  localparam int MBI_EXT_W = 4;
  localparam int MBI_ADDR_W = 16 + MBI_EXT_W;
  localparam int MBI_BURST_LOW_W = 4;
  localparam logic [MBI_ADDR_W-1:0] MBI_ADDR_RST = 20'h00000;
  localparam logic [MBI_PORT_W-1:0] MBI_BYTE_RST = 8'h00;
  // extra address port selector
  localparam logic [1:0] MBI_EXT_PA = 2'h0;
  localparam logic [1:0] MBI_EXT_PB = 2'h1;
  localparam logic [1:0] MBI_EXT_PC = 2'h2;
  localparam logic [1:0] MBI_EXT_PF = 2'h3;
endpackage : mbi_pkg
`default_nettype wire

// ### core/mbi_sync.sv
`default_nettype none
module mbi_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_q;
  always_comb begin
    next_s1 = d;
    next_q = s1;
  end
  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1 <= '0;
      q <= '0;
    end else begin
      s1 <= next_s1;
      q <= next_q;
    end
  end
endmodule : mbi_sync
`default_nettype wire

// ### core/mbi_sel.sv
`default_nettype none
module mbi_sel
  import mbi_pkg::*;
#(
  parameter int N = MBI_NUM_SEL
) (
  input wire logic [N-1:0] sel_term,
  input wire logic [N-1:0] sel_active_low,
  input wire logic [N-1:0] sel_to_port_f,
  input wire logic [N-1:0] sel_oe_term,
  input wire logic [N-1:0] dir_port_c,
  input wire logic [N-1:0] dir_port_f,
  output logic [N-1:0] port_c_sel_out,
  output logic [N-1:0] port_c_sel_oe,
  output logic [N-1:0] port_f_sel_out,
  output logic [N-1:0] port_f_sel_oe
);
  initial begin
    if (N < 1 || N > MBI_NUM_SEL) $error("mbi_sel: bad select count");
  end
  for (genvar i = 0; i < N; i++) begin : g_sel
    logic lvl;
    assign lvl = sel_term[i] ^ sel_active_low[i];
    assign port_c_sel_out[i] = sel_to_port_f[i] ? 1'b0 : lvl;
    assign port_f_sel_out[i] = sel_to_port_f[i] ? lvl : 1'b0;
    assign port_c_sel_oe[i] = !sel_to_port_f[i] && (sel_oe_term[i] || dir_port_c[i]);
    assign port_f_sel_oe[i] = sel_to_port_f[i] && (sel_oe_term[i] || dir_port_f[i]);
  end
endmodule : mbi_sel
`default_nettype wire

// ### core/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// ### dv/mbi_host.sv
`default_nettype none
module mbi_host (
  input wire logic mclk,
  output logic [7:0] ad,
  output logic [7:0] pf,
  output logic ale,
  output logic [2:0] ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ================================================================
  // host side of the bus; control strobes idle high
  initial begin
    ad = 8'h00;
    pf = 8'h00;
    ale = 1'b0;
    ctl = 3'h7;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // strobe stands 4 cycles, address held past its fall
  task automatic latch(input logic [7:0] a);
    ad = a;
    ale = 1'b1;
    cyc(4);
    ale = 1'b0;
    cyc(4);
    ad = ~a; // released bus must not look like a stale address
    cyc(2);
  endtask : latch
  task automatic strobes(input logic [2:0] v);
    ctl = v;
    cyc(4);
  endtask : strobes
  // page and burst hosts move only the low lines
  task automatic low_lines(input logic [7:0] v);
    pf = v;
    cyc(4);
  endtask : low_lines
endmodule : mbi_host
`default_nettype wire

// ### dv/test_mbi_bus_if.sv
`default_nettype none
module test_mbi_bus_if;
  import mbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, lsu, hit, oe, fo, ert, ewr, lit, mrd, mft, mwr;
  mbi_mode_t mode;
  mbi_strobe_t smap;
  logic [1:0] ext, hg;
  logic [3:0] pa, pb, pc;
  logic [7:0] ad, pf, rdat, dout, ae, st, al, tf, ot, dc, df, co, ce, fso, fse, pfo, af, ag;
  logic [2:0] ctl;
  logic ale;
  logic [19:0] ha;
  int errors, tests_run, i;
  mbi_host host (.mclk(mclk), .ad(ad), .pf(pf), .ale(ale), .ctl(ctl));
  mbi_bus_if dut (.mclk(mclk), .sys_rst(sys_rst), .bus_mode(mode), .strobe_map(smap),
    .ext_addr_port(ext), .addr_out_high_g(hg), .latch_strobe_used(lsu),
    .addr_data_port_in(ad), .addr_data_port_out(dout), .addr_data_port_oe(oe),
    .port_f_in(pf), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
    .port_d_bit_zero(ale), .control_input_first(ctl[0]), .control_input_second(ctl[1]),
    .control_input_third(ctl[2]), .resource_hit(hit), .read_data(rdat),
    .port_f_data_out(pfo), .port_f_data_oe(fo), .host_addr(ha), .mem_rd(mrd), .mem_wr(mwr),
    .mem_fetch(mft), .logic_input_third(lit), .ext_rd_strobe(ert), .ext_wr_strobe(ewr),
    .addr_out_e(ae), .addr_out_f(af), .addr_out_g(ag), .sel_term(st), .sel_active_low(al),
    .sel_to_port_f(tf), .sel_oe_term(ot), .dir_port_c(dc), .dir_port_f(df),
    .port_c_sel_out(co), .port_c_sel_oe(ce), .port_f_sel_out(fso), .port_f_sel_oe(fse));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ================================================================
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // ================================================================
  initial begin
    errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    mode = MBI_MUX_LOW;
    smap = MBI_STB_RD_PROGRAM_FETCH_STROBE;
    ext = MBI_EXT_PA;
    hg = 2'h0;
    lsu = 1'b1;
    hit = 1'b0;
    rdat = 8'h3c;
    {pa, pb, pc} = 12'ha36;
    {st, al, tf} = 24'ha6_0f_f0;
    {ot, dc, df} = 24'h81_02_40;
    host.cyc(12);
    chk("oe in reset", 20'h0, {oe, fo});
    chk("addr in reset", 20'h0, ha);
    chk("strobes in reset", 20'h0, {mrd, mwr, mft});
    sys_rst = 1'b0;
    host.cyc(3);
    host.latch(8'h5c);
    chk("low byte", 20'h5c, ha[7:0]);
    chk("addr out e", 20'h5c, ae);
    for (i = 0; i < 3; i++) begin
      ext = i[1:0];
      host.latch(8'h5c);
      chk("extra addr", {16'h0, i == 0 ? 4'ha : i == 1 ? 4'h3 : 4'h6}, ha[19:16]);
    end
    lsu = 1'b0;
    host.latch(8'h11);
    chk("unused strobe", 20'h5c, ha[7:0]);
    lsu = 1'b1;
    host.strobes(3'h5);
    chk("read no hit", 20'h0, oe);
    chk("mem read", 20'h1, mrd);
    hit = 1'b1;
    host.cyc(2);
    chk("read hit", 20'h13c, {oe, dout});
    host.strobes(3'h3);
    chk("fetch third", 20'h3, {oe, mft});
    host.strobes(3'h7);
    chk("idle", 20'h0, oe);
    host.strobes(3'h6);
    chk("mem write", 20'h2, {mwr, oe});
    host.strobes(3'h7);
    smap = MBI_STB_PROGRAM_FETCH_STROBE_ONLY;
    host.strobes(3'h5);
    chk("single read", 20'h3, {mrd, mft, oe});
    host.strobes(3'h7);
    smap = MBI_STB_RD_PROGRAM_FETCH_STROBE;
    mode = MBI_NONMUX;
    host.cyc(4);
    chk("nonmux idle", 20'h0, fo);
    rdat = 8'h5a;
    host.strobes(3'h5);
    chk("nonmux read", {11'h0, 9'h15a}, {11'h0, fo, pfo});
    chk("nonmux ad idle", 20'h0, oe);
    host.strobes(3'h7);
    chk("nonmux release", 20'h0, fo);
    lsu = 1'b0;
    ext = MBI_EXT_PB;
    host.latch(8'h42);
    host.cyc(4);
    chk("nonmux addr", {4'h3, 8'h00, 8'hbd}, ha);
    ext = MBI_EXT_PF;
    host.cyc(4);
    chk("nonmux no f ext", 20'h0, ha[19:16]);
    lsu = 1'b1;
    mode = MBI_MUX_PAGE;
    host.latch(8'h9d);
    for (i = 0; i < 4; i++) begin
      host.low_lines(8'h21 * i[7:0]);
      chk("page hit", {4'h0, 8'h9d, 8'h21 * i[7:0]}, {4'h0, ha[15:0]});
    end
    hg = 2'h1;
    host.cyc(1);
    chk("addr out g high", 20'h9d, ag);
    hg = 2'h0;
    host.cyc(1);
    chk("addr out f g", 20'h5c5c, {af, ag});
    mode = MBI_MUX_BURST;
    host.latch(8'h7e);
    for (i = 0; i < 16; i++) begin
      host.low_lines(i[7:0]);
      chk("burst", {8'h0, 8'h7e, i[3:0]}, {8'h0, ha[11:0]});
    end
    mode = MBI_MUX_EN_RW;
    host.strobes(3'h3);
    chk("en read", 20'h2, {ert, ewr});
    host.strobes(3'h2);
    chk("en write", 20'h1, {ert, ewr});
    mode = MBI_MUX_LOW;
    smap = MBI_STB_RD_ONLY;
    host.strobes(3'h3);
    chk("third low", 20'h0, lit);
    host.strobes(3'h7);
    chk("third high", 20'h1, lit);
    for (i = 0; i < 2; i++) begin
      {st, al, tf} = (i == 0) ? 24'ha6_0f_f0 : 24'h59_f0_0f;
      {ot, dc, df} = (i == 0) ? 24'h81_02_40 : 24'h3c_c3_a5;
      host.cyc(1);
      chk("sel c", {12'h0, (st ^ al) & ~tf}, {12'h0, co});
      chk("sel f", {12'h0, (st ^ al) & tf}, {12'h0, fso});
      chk("oe c", {12'h0, (ot | dc) & ~tf}, {12'h0, ce});
      chk("oe f", {12'h0, (ot | df) & tf}, {12'h0, fse});
    end
    end_sim();
  end
endmodule : test_mbi_bus_if
`default_nettype wire
